/* mps_sequencer.sv */
// Microprogram sequencer of the formatter controller: control store,
// next-address logic, return stack, latches, micro-orders and counters.
// Assumes the store loader, condition inputs and command request come
// from logic on clk_in, so none of them is resynchronised.
`timescale 1ns/10ps

module mps_sequencer #(
  parameter int NUM_LATCH = 32, // Addressable latches
  parameter int STACK_DEPTH = 4, // Return stack entries
  parameter int NUM_COND = 16, // External condition inputs
  parameter bit PARITY_ODD = 1'b1 // Expected word parity
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic store_we_in, // Control store load strobe
  input wire logic [11:0] store_addr_in, // Load address
  input wire logic [15:0] store_data_in, // Load word
  input wire logic [NUM_COND-1:0] cond_in, // Test conditions
  input wire logic cmd_req_in, // Host command request
  input wire logic [7:0] tu_status_in, // Tape unit status
  output logic [11:0] addr_out, // Current microword address
  output logic [NUM_LATCH-1:0] latch_out, // Addressable latches
  output mps_pkg::mps_mo_t mo_out, // Micro-order strobes
  output logic [7:0] general_purpose_count_out, // General purpose count
  output logic [7:0] vcc_out, // Velocity check count
  output logic [7:0] bgroup_out, // Branch group register
  output mps_pkg::mps_status_t status_out, // Reported status
  output logic status_valid_out, // Status pulse
  output logic busy_out, // Controller owns formatter
  output logic parity_err_out // Sticky parity fault
);

  localparam int LW = $clog2(NUM_LATCH);
  localparam int SW = $clog2(STACK_DEPTH);

  // Control store, loaded before the sequencer is released
  logic [15:0] store_q [0:4095];

  mps_pkg::mps_state_t state_q; // Fetch or execute phase
  logic [11:0] pc_q; // Address of current word
  logic [15:0] ir_q; // Fetched microword
  logic [11:0] link_q; // Call target
  logic [11:0] stack_q [0:STACK_DEPTH-1]; // Return stack
  logic [SW-1:0] sp_q; // Next free stack slot
  logic [NUM_LATCH-1:0] latch_q; // Latch bank
  mps_pkg::mps_mo_t mo_q; // Micro-order strobes
  logic [7:0] gp_count_q; // General purpose count
  logic [7:0] vcc_q; // Velocity check count
  logic [7:0] bg_q; // Branch group
  mps_pkg::mps_status_t stat_q; // Status snapshot
  logic stat_v_q; // Status reported pulse
  logic pend_q; // Command waiting to start
  logic busy_q; // Command in progress
  logic perr_q; // Parity fault flag

  // Decoded fields of the word in execution
  logic [6:0] op; // Operation byte less parity
  logic [2:0] cls; // Class field, three bits
  logic [7:0] arg; // Second byte
  logic exec; // Executing this cycle
  logic is_call; // Call flavour
  logic is_ret; // Return flavour
  logic is_latch_set; // Latch set flavour
  logic is_ral; // Latch reset flavour
  logic is_smo; // Micro-order set flavour
  logic take; // Selected condition true
  logic [31:0] cond_vec; // All testable conditions
  logic [11:0] pc_d; // Next address
  logic [11:0] top; // Stack top

  // Wrap-around increment of a store address
  function automatic logic [11:0] inc_addr(input logic [11:0] a);
    inc_addr = a + 12'h001;
  endfunction : inc_addr

  // Membership test of an opcode against a flavour trio
  function automatic logic op_in(input logic [6:0] o, input logic [6:0] a,
                                 input logic [6:0] b, input logic [6:0] c);
    op_in = (o == a) || (o == b) || (o == c);
  endfunction : op_in

  assign op = ir_q[mps_pkg::OP_HI:mps_pkg::OP_LO];
  assign cls = ir_q[mps_pkg::CLS_HI:mps_pkg::CLS_LO];
  assign arg = ir_q[7:0];
  assign exec = (state_q == mps_pkg::ST_EXEC);
  assign is_call = op_in(op, mps_pkg::OP_CALL, mps_pkg::OP_LATCH_SET_CALL, mps_pkg::OP_SMO_CALL)
                   || (op == mps_pkg::OP_RAL_CALL);
  assign is_ret = op_in(op, mps_pkg::OP_RET, mps_pkg::OP_LATCH_SET_RET, mps_pkg::OP_SMO_RET)
                  || (op == mps_pkg::OP_RAL_RET);
  assign is_latch_set = op_in(op, mps_pkg::OP_LATCH_SET, mps_pkg::OP_LATCH_SET_CALL, mps_pkg::OP_LATCH_SET_RET);
  assign is_ral = op_in(op, mps_pkg::OP_RAL, mps_pkg::OP_RAL_CALL, mps_pkg::OP_RAL_RET);
  assign is_smo = op_in(op, mps_pkg::OP_SMO, mps_pkg::OP_SMO_CALL, mps_pkg::OP_SMO_RET);
  assign top = stack_q[sp_q - SW'(1)];

  // Internal states join the external inputs so the microprogram can poll them
  assign cond_vec = 32'({latch_q[7:0], pend_q, busy_q, (vcc_q == 8'h00), (gp_count_q == 8'h00),
                         4'h0, cond_in});
  assign take = cond_vec[ir_q[mps_pkg::CSEL_HI:mps_pkg::CSEL_LO]];

  // Next-address selection; plain words and unknown codes fall through
  always_comb begin
    pc_d = inc_addr(pc_q);
    unique case (cls)
      mps_pkg::CLS_BRL: begin
        pc_d = ir_q[11:0];
      end
      mps_pkg::CLS_CBR_LO, mps_pkg::CLS_CBR_HI: begin
        // Target stays in the current sector; a false test falls through
        if (take) begin
          pc_d = {pc_q[11:mps_pkg::SECT_W], arg};
        end else begin
          pc_d = inc_addr(pc_q);
        end
      end
      default: begin
        if (is_call) begin
          pc_d = link_q;
        end else if (is_ret) begin
          pc_d = top;
        end
      end
    endcase
  end

  // Store loading port
  always_ff @(posedge clk_in) begin
    if (store_we_in) begin
      store_q[store_addr_in] <= store_data_in;
    end
  end

  // Two-phase fetch and execute with trap to zero on reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_q <= mps_pkg::ST_FETCH;
      pc_q <= mps_pkg::RESET_ADDR;
      ir_q <= 16'h0000;
    end else if (exec) begin
      state_q <= mps_pkg::ST_FETCH;
      pc_q <= pc_d;
    end else begin
      state_q <= mps_pkg::ST_EXEC;
      ir_q <= store_q[pc_q];
    end
  end

  // Parity over the whole word; the fault sticks until reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      perr_q <= 1'b0;
    end else if (exec && ((^ir_q) != PARITY_ODD)) begin
      perr_q <= 1'b1;
    end
  end

  // Link register and return stack; overflow silently wraps
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      link_q <= mps_pkg::RESET_ADDR;
      sp_q <= '0;
    end else if (exec && cls < mps_pkg::CLS_CBR_LO) begin
      if (is_call || op == mps_pkg::OP_PUSH) begin
        stack_q[sp_q] <= is_call ? inc_addr(pc_q) : link_q;
        sp_q <= sp_q + SW'(1);
      end else if (is_ret || op == mps_pkg::OP_POP) begin
        sp_q <= sp_q - SW'(1);
        if (op == mps_pkg::OP_POP) begin
          link_q <= top;
        end
      end
    end else if (exec && cls == mps_pkg::CLS_LLR) begin
      link_q <= ir_q[11:0];
    end
  end

  // Addressable latch bank
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      latch_q <= '0;
    end else if (exec && cls < mps_pkg::CLS_CBR_LO) begin
      if (is_latch_set) begin
        latch_q[arg[LW-1:0]] <= 1'b1;
      end else if (is_ral) begin
        latch_q[arg[LW-1:0]] <= 1'b0;
      end
    end
  end

  // Micro-order strobes last one cycle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mo_q <= '0;
    end else begin
      mo_q.set <= exec && cls < mps_pkg::CLS_CBR_LO && is_smo;
      mo_q.rst <= exec && op == mps_pkg::OP_RMO;
      mo_q.code <= exec ? arg : mo_q.code;
    end
  end

  // Timing counters count down to zero; branch group holds its load
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      gp_count_q <= mps_pkg::CNT_RST;
      vcc_q <= mps_pkg::CNT_RST;
      bg_q <= mps_pkg::BG_RST;
    end else begin
      if (exec && op == mps_pkg::OP_LGPC) begin
        gp_count_q <= arg;
      end else if (gp_count_q != 8'h00) begin
        gp_count_q <= gp_count_q - 8'h01;
      end
      if (exec && op == mps_pkg::OP_VCL) begin
        vcc_q <= arg;
      end else if (vcc_q != 8'h00) begin
        vcc_q <= vcc_q - 8'h01;
      end
      if (exec && op == mps_pkg::OP_LBG) begin
        bg_q <= arg;
      end
    end
  end

  // Command hand-off: status first, then ownership until the done order
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      stat_q <= '0;
      stat_v_q <= 1'b0;
      pend_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      stat_v_q <= 1'b0;
      if (cmd_req_in && !pend_q && !busy_q) begin
        // Requests during a command are ignored so nothing can preempt it
        stat_q <= '{tu: tu_status_in, fmt: {perr_q, latch_q[6:0]}};
        stat_v_q <= 1'b1;
        pend_q <= 1'b1;
      end else if (pend_q) begin
        pend_q <= 1'b0;
        busy_q <= 1'b1;
      end else if (exec && cls < mps_pkg::CLS_CBR_LO && is_smo && arg == mps_pkg::MO_DONE) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Outputs come straight from flops
  assign addr_out = pc_q;
  assign latch_out = latch_q;
  assign mo_out = mo_q;
  assign general_purpose_count_out = gp_count_q;
  assign vcc_out = vcc_q;
  assign bgroup_out = bg_q;
  assign status_out = stat_q;
  assign status_valid_out = stat_v_q;
  assign busy_out = busy_q;
  assign parity_err_out = perr_q;

endmodule : mps_sequencer

/* mps_pkg.sv */
// Shared constants and carrier types for the microprogram sequencer.
// Assumes a single 20 MHz clock domain and a synchronous active-high reset.
package mps_pkg;

  // Control store geometry
  localparam int ADDR_W = 12; // 4K words
  localparam int WORD_W = 16; // Microword width
  localparam int SECT_W = 8; // 256-word sector
  localparam logic [11:0] RESET_ADDR = 12'h000; // Trap address

  // Microword field positions (bit 15 carries parity)
  localparam int PAR_BIT = 15;
  localparam int OP_HI = 14;
  localparam int OP_LO = 8;
  localparam int CLS_HI = 14;
  localparam int CLS_LO = 12;
  localparam int CSEL_HI = 12;
  localparam int CSEL_LO = 8;

  // Instruction classes taken from the top three opcode bits
  localparam logic [2:0] CLS_CBR_LO = 3'h4; // Conditional branch, low conditions
  localparam logic [2:0] CLS_CBR_HI = 3'h5; // Conditional branch, high conditions
  localparam logic [2:0] CLS_LLR = 3'h6; // Load link register
  localparam logic [2:0] CLS_BRL = 3'h7; // Long branch, full span

  // Seven-bit operation codes
  localparam logic [6:0] OP_NOP = 7'h00;
  localparam logic [6:0] OP_PUSH = 7'h01;
  localparam logic [6:0] OP_POP = 7'h02;
  localparam logic [6:0] OP_CALL = 7'h03;
  localparam logic [6:0] OP_LATCH_SET = 7'h10;
  localparam logic [6:0] OP_LATCH_SET_CALL = 7'h11;
  localparam logic [6:0] OP_LATCH_SET_RET = 7'h12;
  localparam logic [6:0] OP_RET = 7'h13;
  localparam logic [6:0] OP_SMO = 7'h14;
  localparam logic [6:0] OP_SMO_CALL = 7'h15;
  localparam logic [6:0] OP_SMO_RET = 7'h16;
  localparam logic [6:0] OP_RAL = 7'h20;
  localparam logic [6:0] OP_RAL_CALL = 7'h21;
  localparam logic [6:0] OP_RAL_RET = 7'h22;
  localparam logic [6:0] OP_RMO = 7'h24;
  localparam logic [6:0] OP_VCL = 7'h27;
  localparam logic [6:0] OP_LBG = 7'h30;
  localparam logic [6:0] OP_LGPC = 7'h31;

  // Micro-order code that hands the formatter back to the host side
  localparam logic [7:0] MO_DONE = 8'hff;

  // Reset values
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] BG_RST = 8'h00;

  // Sequencer states, Gray along fetch -> execute
  typedef enum logic [0:0] {
    ST_FETCH = 1'b0,
    ST_EXEC = 1'b1
  } mps_state_t;

  // Micro-order strobe group
  typedef struct packed {
    logic set;
    logic rst;
    logic [7:0] code;
  } mps_mo_t;

  // Status reported before a command starts
  typedef struct packed {
    logic [7:0] tu;
    logic [7:0] fmt;
  } mps_status_t;

endpackage : mps_pkg

/* mps_sequencer_assertions.sv */
// Concurrent checks on the ports of the microprogram sequencer.
// Assumes one clock domain and the design's synchronous active-high reset.
`timescale 1ns/10ps
module mps_sequencer_checker #(
  parameter int NUM_LATCH = 32 // Latch bank width
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic cmd_req_in,
  input wire logic [7:0] tu_status_in,
  input wire logic [11:0] addr_out,
  input wire logic [NUM_LATCH-1:0] latch_out,
  input wire mps_pkg::mps_mo_t mo_out,
  input wire logic [7:0] vcc_out,
  input wire mps_pkg::mps_status_t status_out,
  input wire logic status_valid_out,
  input wire logic busy_out,
  input wire logic parity_err_out
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Status report, then ownership of the formatter
  sequence s_report;
    status_valid_out ##1 busy_out;
  endsequence
  // Hand-back micro-order pulse
  sequence s_done;
    mo_out.set && mo_out.code == 8'hff;
  endsequence
  property p_trap; $fell(srst_in) |-> addr_out == 12'h000 && !busy_out; endproperty
  property p_report; $rose(status_valid_out) |-> s_report; endproperty
  property p_status;
    $rose(status_valid_out) |-> $past(cmd_req_in) && status_out.tu == $past(tu_status_in);
  endproperty
  property p_pulse; status_valid_out |=> !status_valid_out; endproperty
  // The hand-back pulse comes on the same exec edge that drops busy
  property p_release; $fell(busy_out) |-> ##[0:1] s_done; endproperty
  property p_mo; mo_out.set |=> !mo_out.set; endproperty
  property p_sticky; parity_err_out |=> parity_err_out; endproperty
  // Every word takes a fetch and an exec cycle
  property p_two; !$stable(addr_out) |=> $stable(addr_out); endproperty
  property p_latch; !$stable(latch_out) |-> !$stable(addr_out); endproperty
  // A load can only come with an exec edge, else count down by one
  property p_vcc; vcc_out != 8'h00 |=> vcc_out == $past(vcc_out) - 8'h01 || !$stable(addr_out); endproperty
  a_trap: assert property (p_trap) else $error("address not trapped to zero");
  a_report: assert property (p_report) else $error("busy did not follow report");
  a_status: assert property (p_status) else $error("status report wrong");
  a_pulse: assert property (p_pulse) else $error("status pulse too long");
  a_release: assert property (p_release) else $error("busy dropped without hand-back");
  a_mo: assert property (p_mo) else $error("micro-order pulse too long");
  a_sticky: assert property (p_sticky) else $error("parity fault not held");
  a_two: assert property (p_two) else $error("address stepped early");
  a_latch: assert property (p_latch) else $error("latch changed off exec");
  a_vcc: assert property (p_vcc) else $error("velocity count wrong");
endmodule : mps_sequencer_checker

bind mps_sequencer mps_sequencer_checker #(.NUM_LATCH(NUM_LATCH)) mps_sequencer_checker_inst (.clk_in, .srst_in,
  .cmd_req_in, .tu_status_in, .addr_out, .latch_out, .mo_out, .vcc_out, .status_out, .status_valid_out,
  .busy_out, .parity_err_out);

/* mps_fmt_model.sv */
// Behavioural model of the formatter's condition levels and tape unit status byte.
// Assumes it shares clk_in with the sequencer and changes just after edges.
`timescale 1ns/10ps
module mps_fmt_model (
  input wire logic clk_in,
  input wire logic busy_in, // Formatter owned by the sequencer
  output logic [15:0] cond_out, // Test condition levels
  output logic [7:0] tu_status_out // Tape unit status byte
);
  // Condition 1 true, all others false; held as levels
  assign cond_out = 16'h0002;
  // Status moves while the tape is running, so a late sample shows up
  always_ff @(posedge clk_in) begin
    tu_status_out <= busy_in ? 8'h3c : 8'h5a;
  end
endmodule : mps_fmt_model

/* mps_sequencer_tb.sv */
// Directed bench for the microprogram sequencer and its formatter model.
// Assumes the checker is bound in and all parts share clk_in.
`timescale 1ns/10ps
`define CHK(nm, got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module mps_sequencer_tb;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1; // Held through the store load
  logic store_we_in = 1'b0;
  logic [11:0] store_addr_in = 12'h000;
  logic [15:0] store_data_in = 16'h0000;
  logic cmd_req_in = 1'b0;
  logic [15:0] cond_in; // From the formatter model
  logic [7:0] tu_status_in;
  logic [11:0] addr_out;
  logic [31:0] latch_out;
  mps_pkg::mps_mo_t mo_out;
  logic [7:0] vcc_out;
  mps_pkg::mps_status_t status_out;
  logic status_valid_out;
  logic busy_out;
  logic parity_err_out;
  logic mo_seen = 1'b0; // Set pulse observed
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  mps_sequencer mps_sequencer_inst (.clk_in, .srst_in, .store_we_in, .store_addr_in, .store_data_in, .cond_in,
    .cmd_req_in, .tu_status_in, .addr_out, .latch_out, .mo_out, .general_purpose_count_out(), .vcc_out, .bgroup_out(),
    .status_out, .status_valid_out, .busy_out, .parity_err_out);
  mps_fmt_model mps_fmt_model_inst (.clk_in, .busy_in(busy_out), .cond_out(cond_in), .tu_status_out(tu_status_in));
  // 20 MHz clock
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  // Pulses last one cycle, so catch them at the edge
  always @(posedge clk_in) begin
    if (mo_out.set === 1'b1) mo_seen <= 1'b1;
  end
  // The run needs well under 100 cycles; a hang ends here
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      report_and_stop();
    end
  end
  // Odd-parity microword: top bit makes the XOR of all bits one
  function automatic logic [15:0] mw(input logic [6:0] op, input logic [7:0] a);
    mw = {~^{op, a}, op, a};
  endfunction : mw
  task automatic put(input logic [11:0] a, input logic [15:0] d);
    @(negedge clk_in);
    store_we_in = 1'b1;
    store_addr_in = a;
    store_data_in = d;
  endtask : put
  // One word is fetch plus exec, so two cycles per address
  task automatic step(input logic [11:0] exp);
    repeat (2) @(negedge clk_in);
    `CHK("addr_out", addr_out, exp);
  endtask : step
  // Program loaded under reset, which the store allows
  task automatic test_load();
    put(12'h000, mw(7'h60, 8'h40));
    put(12'h001, mw(7'h10, 8'h03));
    put(12'h002, mw(7'h03, 8'h00));
    put(12'h040, mw(7'h27, 8'h05));
    put(12'h041, mw(7'h13, 8'h00));
    put(12'h003, mw(7'h42, 8'h10));
    put(12'h004, mw(7'h41, 8'h20));
    put(12'h020, mw(7'h78, 8'h00));
    put(12'h800, mw(7'h14, 8'h42));
    put(12'h801, mw(7'h20, 8'h03));
    put(12'h802, mw(7'h00, 8'h00) ^ 16'h8000);
    put(12'h803, mw(7'h14, 8'hff));
    put(12'h804, mw(7'h78, 8'h04));
    @(negedge clk_in);
    store_we_in = 1'b0;
    $display("test_load done");
  endtask : test_load
  // Command taken at release, then sequential, call, return and branches
  task automatic test_calls();
    cmd_req_in = 1'b1;
    // The status pulse stands only in the cycle after the request edge
    @(negedge clk_in);
    `CHK("status_valid_out", status_valid_out, 1'b1);
    `CHK("status_out", status_out, 16'h5a00);
    cmd_req_in = 1'b0;
    @(negedge clk_in);
    `CHK("addr_out", addr_out, 12'h001);
    step(12'h002);
    `CHK("latch_out[3]", latch_out[3], 1'b1);
    `CHK("busy_out", busy_out, 1'b1);
    step(12'h040);
    step(12'h041);
    `CHK("vcc_out", vcc_out, 8'h05);
    step(12'h003);
    `CHK("vcc_out", vcc_out, 8'h03);
    step(12'h004);
    step(12'h020);
    $display("test_calls done");
  endtask : test_calls
  // Long branch, micro-order, latch clear, parity fault and hand-back
  task automatic test_long();
    step(12'h800);
    step(12'h801);
    // Code is replaced by the next executed word, so look before it runs
    `CHK("mo_out.code", mo_out.code, 8'h42);
    step(12'h802);
    `CHK("mo_seen", mo_seen, 1'b1);
    `CHK("latch_out[3]", latch_out[3], 1'b0);
    step(12'h803);
    `CHK("parity_err_out", parity_err_out, 1'b1);
    `CHK("busy_out", busy_out, 1'b1);
    step(12'h804);
    step(12'h804);
    `CHK("busy_out", busy_out, 1'b0);
    $display("test_long done");
  endtask : test_long
  // Reset in mid-run traps to zero and restarts there
  task automatic test_reset();
    srst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    `CHK("addr_out", addr_out, 12'h000);
    `CHK("latch_out", latch_out, 32'h00000000);
    `CHK("parity_err_out", parity_err_out, 1'b0);
    srst_in = 1'b0;
    step(12'h001);
    $display("test_reset done");
  endtask : test_reset
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    test_load();
    srst_in = 1'b0;
    test_calls();
    test_long();
    test_reset();
    report_and_stop();
  end
endmodule : mps_sequencer_tb
